// ### design/vc2_poh_pkg.sv
`default_nettype none
package vc2_poh_pkg;
  localparam int unsigned FRAME_BYTES = 428;
  localparam int unsigned CNT_W = 9;
  localparam logic [8:0] POS_V5 = 9'h000;
  localparam logic [8:0] POS_J2 = 9'h06b;
  localparam logic [8:0] POS_K4 = 9'h141;
  localparam logic [8:0] POS_LAST = 9'h1ab;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [2:0] LABEL_UNEQUIPPED = 3'h0;
  localparam logic [7:0] TRACE_RESET = 8'h00;
  localparam int unsigned STAT_W = 15;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : vc2_poh_pkg
`default_nettype wire

// ### design/level_sync.sv
`default_nettype none
module level_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // first stage is read only by the second stage
  always_comb
  begin
    meta_d = i_d;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_q = sync_q;
endmodule : level_sync
`default_nettype wire

// ### design/vc2_path_overhead_termination.sv
`default_nettype none
// Behaviour
// (R01) the source puts the configured transmitted trace id into the J2 byte of every frame.
// (R02) the source writes V5 bit 3 as 0 for zero remote violations and 1 for one or two.
// (R03) the source sets V5 bit 8 within 1000 us of the remote defect input rising and clears it likewise.
// (R04) the source fills V5 bits 1 and 2 with even parity over odd and even bits of the whole previous frame.
// (R05) the source may leave any value in K4 bits 5 to 8.
// (R06) the sink captures each J2 byte and presents it as the accepted trace id.
// (R07) the sink checks BIP-2 of the previous frame, V5 included, against current V5 bits 1 and 2.
// (R08) the sink extracts V5 bit 3 each frame as the far-end block error.
// (R09) the sink extracts V5 bit 8 as remote receiver status, 1 meaning remote defect.
// (R10) the sink ignores K4 bits 5 to 8.
// (R11) the sink extracts V5 bits 5 to 7 each frame for unequipped detection.
// (R12) the sink forces all-ones data within 1000 us of alarm insertion and restores it likewise.
// (R13) the sink passes its per-frame violation count and remote defect decision to the paired source.
module vc2_path_overhead_termination (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic [7:0] i_transmitted_trace_id,
  input wire logic i_alarm_insert_action,
  input wire logic [7:0] i_src_data,
  input wire logic i_src_fs,
  input wire logic [1:0] i_remote_error_count_in,
  input wire logic i_remote_defect_in,
  output logic [7:0] o_src_data,
  output logic o_src_fs,
  input wire logic [7:0] i_snk_data,
  input wire logic i_snk_fs,
  input wire logic i_snk_ssf,
  output logic [7:0] o_snk_data,
  output logic o_snk_fs,
  output logic [1:0] o_remote_error_count,
  output logic o_remote_defect,
  output logic [7:0] o_accepted_trace_id,
  output logic [2:0] o_signal_label,
  output logic o_unequipped,
  output logic o_remote_receiver_defect,
  output logic o_near_end_block_error,
  output logic o_far_end_block_error
);
  function automatic logic [1:0] bip_of(input logic [7:0] b);
    bip_of = {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
  endfunction : bip_of

  function automatic logic [8:0] next_pos(input logic [8:0] p);
    next_pos = (p == vc2_poh_pkg::POS_LAST) ? 9'h000 : 9'(p + 9'h001);
  endfunction : next_pos

  // config crossing into the link domain; trace id is static while provisioned
  logic [7:0] tx_trace_l;
  logic ais_l;
  level_sync #(.W(9)) u_cfg_sync (
    .i_clk(i_link_clk),
    .i_rst(i_rst),
    .i_d({i_transmitted_trace_id, i_alarm_insert_action}),
    .o_q({tx_trace_l, ais_l})
  );

  // source, link domain
  logic [8:0] src_cnt_q, src_cnt_d;
  logic [1:0] src_acc_q, src_acc_d;
  logic [7:0] src_data_q, src_data_d;
  logic src_fs_q, src_fs_d;
  logic [8:0] src_pos;

  always_comb
  begin
    src_pos = i_src_fs ? vc2_poh_pkg::POS_V5 : src_cnt_q;
    src_data_d = i_src_data; // K4 and payload pass through, see (R05)
    if (src_pos == vc2_poh_pkg::POS_V5)
    begin
      // parity of the previous frame as sent, see (R04)
      // rei bit, see (R02); rdi bit follows input each frame, see (R03)
      src_data_d = {src_acc_q, i_remote_error_count_in != 2'h0, i_src_data[4:1], i_remote_defect_in};
    end
    else if (src_pos == vc2_poh_pkg::POS_J2)
    begin
      src_data_d = tx_trace_l; // see (R01)
    end
    src_acc_d = (src_pos == vc2_poh_pkg::POS_V5) ? bip_of(src_data_d) : src_acc_q ^ bip_of(src_data_d); // see (R04)
    src_cnt_d = next_pos(src_pos);
    src_fs_d = i_src_fs;
  end

  always_ff @(posedge i_link_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      src_cnt_q <= 9'h000;
      src_acc_q <= 2'h0;
      src_data_q <= 8'h00;
      src_fs_q <= 1'b0;
    end
    else
    begin
      src_cnt_q <= src_cnt_d;
      src_acc_q <= src_acc_d;
      src_data_q <= src_data_d;
      src_fs_q <= src_fs_d;
    end
  end

  assign o_src_data = src_data_q;
  assign o_src_fs = src_fs_q;

  // sink, link domain
  logic [8:0] snk_cnt_q, snk_cnt_d;
  logic [1:0] snk_acc_q, snk_acc_d;
  logic snk_seen_q, snk_seen_d;
  logic [7:0] snk_data_q, snk_data_d;
  logic snk_fs_q, snk_fs_d;
  logic [1:0] rec_q, rec_d;
  logic rdi_out_q, rdi_out_d;
  logic [7:0] j2_q, j2_d;
  logic [2:0] label_q, label_d;
  logic [vc2_poh_pkg::STAT_W-1:0] stat_q, stat_d;
  logic tog_q, tog_d;
  logic [8:0] snk_pos;
  logic [1:0] diff;

  always_comb
  begin
    // flywheel parks until the first frame start, else a partial frame would be checked
    snk_pos = i_snk_fs ? vc2_poh_pkg::POS_V5 : (snk_seen_q ? snk_cnt_q : vc2_poh_pkg::POS_LAST);
    snk_cnt_d = next_pos(snk_pos);
    snk_acc_d = snk_acc_q ^ bip_of(i_snk_data);
    snk_seen_d = snk_seen_q;
    rec_d = rec_q;
    j2_d = j2_q;
    label_d = label_q;
    stat_d = stat_q;
    tog_d = tog_q;
    diff = snk_acc_q ^ i_snk_data[7:6];
    if (snk_pos == vc2_poh_pkg::POS_V5)
    begin
      snk_acc_d = bip_of(i_snk_data); // parity covers V5 too, see (R07)
      snk_seen_d = 1'b1;
      // no previous frame to check on the first V5
      rec_d = snk_seen_q ? 2'(diff[1] + diff[0]) : 2'h0; // see (R07) (R13)
      label_d = i_snk_data[3:1]; // see (R11)
      // far-end bit, see (R08); remote status, see (R09); trace, see (R06)
      stat_d = {j2_q, i_snk_data[3:1], i_snk_data[0], i_snk_data[5], rec_d};
      tog_d = ~tog_q;
    end
    else if (snk_pos == vc2_poh_pkg::POS_J2)
    begin
      j2_d = i_snk_data; // see (R06)
    end
    // K4 never inspected, see (R10)
    rdi_out_d = i_snk_ssf | (label_q == vc2_poh_pkg::LABEL_UNEQUIPPED); // see (R13)
    snk_data_d = ais_l ? vc2_poh_pkg::ALL_ONES : i_snk_data; // see (R12)
    snk_fs_d = i_snk_fs;
  end

  always_ff @(posedge i_link_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      snk_cnt_q <= 9'h000;
      snk_acc_q <= 2'h0;
      snk_seen_q <= 1'b0;
      snk_data_q <= 8'h00;
      snk_fs_q <= 1'b0;
      rec_q <= 2'h0;
      rdi_out_q <= 1'b0;
      j2_q <= vc2_poh_pkg::TRACE_RESET;
      label_q <= vc2_poh_pkg::LABEL_UNEQUIPPED;
      stat_q <= '0;
      tog_q <= 1'b0;
    end
    else
    begin
      snk_cnt_q <= snk_cnt_d;
      snk_acc_q <= snk_acc_d;
      snk_seen_q <= snk_seen_d;
      snk_data_q <= snk_data_d;
      snk_fs_q <= snk_fs_d;
      rec_q <= rec_d;
      rdi_out_q <= rdi_out_d;
      j2_q <= j2_d;
      label_q <= label_d;
      stat_q <= stat_d;
      tog_q <= tog_d;
    end
  end

  assign o_snk_data = snk_data_q;
  assign o_snk_fs = snk_fs_q;
  assign o_remote_error_count = rec_q;
  assign o_remote_defect = rdi_out_q;

  // status crossing: toggle per frame, bundle held a whole frame so it is stable when sampled
  logic tog_s;
  level_sync #(.W(1)) u_tog_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(tog_q),
    .o_q(tog_s)
  );

  logic tog_seen_q, tog_seen_d;
  logic [7:0] trace_q, trace_d;
  logic [2:0] lbl_q, lbl_d;
  logic uneq_q, uneq_d;
  logic rrd_q, rrd_d;
  logic ne_q, ne_d;
  logic fe_q, fe_d;

  always_comb
  begin
    tog_seen_d = tog_s;
    trace_d = trace_q;
    lbl_d = lbl_q;
    uneq_d = uneq_q;
    rrd_d = rrd_q;
    ne_d = 1'b0;
    fe_d = 1'b0;
    if (tog_s != tog_seen_q)
    begin
      trace_d = stat_q[14:7]; // see (R06)
      lbl_d = stat_q[6:4]; // see (R11)
      uneq_d = stat_q[6:4] == vc2_poh_pkg::LABEL_UNEQUIPPED;
      rrd_d = stat_q[3]; // see (R09)
      fe_d = stat_q[2]; // see (R08)
      ne_d = stat_q[1:0] != 2'h0; // see (R07)
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tog_seen_q <= 1'b0;
      trace_q <= vc2_poh_pkg::TRACE_RESET;
      lbl_q <= vc2_poh_pkg::LABEL_UNEQUIPPED;
      uneq_q <= 1'b0;
      rrd_q <= 1'b0;
      ne_q <= 1'b0;
      fe_q <= 1'b0;
    end
    else
    begin
      tog_seen_q <= tog_seen_d;
      trace_q <= trace_d;
      lbl_q <= lbl_d;
      uneq_q <= uneq_d;
      rrd_q <= rrd_d;
      ne_q <= ne_d;
      fe_q <= fe_d;
    end
  end

  assign o_accepted_trace_id = trace_q;
  assign o_signal_label = lbl_q;
  assign o_unequipped = uneq_q;
  assign o_remote_receiver_defect = rrd_q;
  assign o_near_end_block_error = ne_q;
  assign o_far_end_block_error = fe_q;
endmodule : vc2_path_overhead_termination
`default_nettype wire

// ### verif/vc2_poh_monitor.sv
`default_nettype none
module vc2_poh_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic [7:0] i_transmitted_trace_id,
  input wire logic [1:0] i_remote_error_count_in,
  input wire logic i_remote_defect_in,
  input wire logic i_snk_fs,
  input wire logic i_snk_ssf,
  input wire logic [7:0] o_src_data,
  input wire logic o_src_fs,
  input wire logic [1:0] o_remote_error_count,
  input wire logic o_remote_defect,
  input wire logic [2:0] o_signal_label,
  input wire logic o_unequipped,
  input wire logic o_near_end_block_error,
  input wire logic o_far_end_block_error
);
  logic [1:0] par_q, par_d;
  logic seen_q, seen_d;
  // parity restarts on the V5 byte, so it spans exactly one output frame
  always_comb
  begin
    par_d = {^(o_src_data & 8'haa), ^(o_src_data & 8'h55)};
    if (!o_src_fs)
      par_d = par_d ^ par_q;
    seen_d = seen_q | o_src_fs;
  end
  always_ff @(posedge i_link_clk or posedge i_rst)
    if (i_rst)
      {par_q, seen_q} <= '0;
    else
      {par_q, seen_q} <= {par_d, seen_d};
  sequence s_j2_slot;
    o_src_fs ##107 1'b1;
  endsequence
  a_trace_in_j2: assert property (@(posedge i_link_clk) disable iff (i_rst)
    s_j2_slot |-> o_src_data == i_transmitted_trace_id) else $error("j2 not trace");
  a_rei_coding: assert property (@(posedge i_link_clk) disable iff (i_rst)
    o_src_fs |-> o_src_data[5] == ($past(i_remote_error_count_in) != 2'h0)) else $error("rei bit");
  a_rdi_insert: assert property (@(posedge i_link_clk) disable iff (i_rst)
    o_src_fs |-> o_src_data[0] == $past(i_remote_defect_in)) else $error("rdi bit");
  a_bip_insert: assert property (@(posedge i_link_clk) disable iff (i_rst)
    o_src_fs && seen_q |-> o_src_data[7:6] == par_q) else $error("bip bits");
  a_count_at_v5: assert property (@(posedge i_link_clk) disable iff (i_rst)
    $changed(o_remote_error_count) |-> $past(i_snk_fs)) else $error("count moved off v5");
  a_count_range: assert property (@(posedge i_link_clk) disable iff (i_rst)
    o_remote_error_count != 2'h3) else $error("count above two");
  a_ssf_defect: assert property (@(posedge i_link_clk) disable iff (i_rst)
    $past(i_snk_ssf) |-> o_remote_defect) else $error("ssf not passed");
  a_near_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    o_near_end_block_error |=> !o_near_end_block_error) else $error("near pulse long");
  a_far_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    o_far_end_block_error |=> !o_far_end_block_error) else $error("far pulse long");
  a_uneq_label: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_unequipped) |-> o_signal_label == 3'h0) else $error("uneq without label");
endmodule : vc2_poh_monitor
bind vc2_path_overhead_termination vc2_poh_monitor vc2_poh_monitor_inst (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_link_clk(i_link_clk),
  .i_transmitted_trace_id(i_transmitted_trace_id),
  .i_remote_error_count_in(i_remote_error_count_in),
  .i_remote_defect_in(i_remote_defect_in),
  .i_snk_fs(i_snk_fs),
  .i_snk_ssf(i_snk_ssf),
  .o_src_data(o_src_data),
  .o_src_fs(o_src_fs),
  .o_remote_error_count(o_remote_error_count),
  .o_remote_defect(o_remote_defect),
  .o_signal_label(o_signal_label),
  .o_unequipped(o_unequipped),
  .o_near_end_block_error(o_near_end_block_error),
  .o_far_end_block_error(o_far_end_block_error)
);
`default_nettype wire

// ### verif/vc2_adapt_partner.sv
`default_nettype none
module vc2_adapt_partner (
  input wire logic i_link_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_label,
  input wire logic [1:0] i_err,
  input wire logic [7:0] i_loop,
  output logic [7:0] o_data,
  output logic o_fs,
  output logic [7:0] o_snk
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos;
  // matrix loops the source back, inverting bits only when asked
  assign o_snk = i_loop ^ {6'h00, i_err};
  always @(posedge i_link_clk or posedge i_rst)
    if (i_rst)
    begin
      pos <= 0;
      o_fs <= 1'b0;
      o_data <= 8'h00;
    end
    else
    begin
      pos <= (pos == 427) ? 0 : pos + 1;
      o_fs <= (pos == 0);
      o_data <= (pos == 0) ? {4'h0, i_label, 1'b0} : 8'($urandom);
    end
endmodule : vc2_adapt_partner
`default_nettype wire

// ### verif/vc2_path_overhead_termination_bench.sv
`default_nettype none
module vc2_path_overhead_termination_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_link_clk = 0, i_rst = 1, i_alarm_insert_action = 0, i_snk_ssf = 0;
  logic [7:0] i_transmitted_trace_id = 8'h00, prev = 8'h00;
  logic prev_fs = 1'b0;
  logic [2:0] label = 3'h5;
  logic [1:0] err = 2'h0;
  wire logic [7:0] i_src_data, i_snk_data, o_src_data, o_snk_data, o_accepted_trace_id;
  wire logic i_src_fs, o_src_fs, o_snk_fs, o_remote_defect, o_unequipped, o_remote_receiver_defect;
  wire logic o_near_end_block_error, o_far_end_block_error;
  wire logic [1:0] o_remote_error_count;
  wire logic [2:0] o_signal_label;
  wire logic i_snk_fs = o_src_fs;
  wire logic [1:0] i_remote_error_count_in = o_remote_error_count;
  wire logic i_remote_defect_in = o_remote_defect;
  int error_cnt = 0, compares = 0, near_n = 0, far_n = 0, nb, fb;
  initial forever #50 i_clk = ~i_clk;
  initial #7 forever #24 i_link_clk = ~i_link_clk;
  vc2_path_overhead_termination vc2_path_overhead_termination_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_link_clk(i_link_clk),
    .i_transmitted_trace_id(i_transmitted_trace_id),
    .i_alarm_insert_action(i_alarm_insert_action),
    .i_src_data(i_src_data),
    .i_src_fs(i_src_fs),
    .i_remote_error_count_in(i_remote_error_count_in),
    .i_remote_defect_in(i_remote_defect_in),
    .o_src_data(o_src_data),
    .o_src_fs(o_src_fs),
    .i_snk_data(i_snk_data),
    .i_snk_fs(i_snk_fs),
    .i_snk_ssf(i_snk_ssf),
    .o_snk_data(o_snk_data),
    .o_snk_fs(o_snk_fs),
    .o_remote_error_count(o_remote_error_count),
    .o_remote_defect(o_remote_defect),
    .o_accepted_trace_id(o_accepted_trace_id),
    .o_signal_label(o_signal_label),
    .o_unequipped(o_unequipped),
    .o_remote_receiver_defect(o_remote_receiver_defect),
    .o_near_end_block_error(o_near_end_block_error),
    .o_far_end_block_error(o_far_end_block_error)
  );
  vc2_adapt_partner vc2_adapt_partner_inst (
    .i_link_clk(i_link_clk),
    .i_rst(i_rst),
    .i_label(label),
    .i_err(err),
    .i_loop(o_src_data),
    .o_data(i_src_data),
    .o_fs(i_src_fs),
    .o_snk(i_snk_data)
  );
  always @(posedge i_clk)
  begin
    near_n <= near_n + int'(o_near_end_block_error);
    far_n <= far_n + int'(o_far_end_block_error);
  end
  always @(posedge i_link_clk)
  begin
    prev <= i_snk_data;
    prev_fs <= i_snk_fs;
  end
  // remote defect decision: server fail or unequipped label
  function automatic logic expect_rdi(input logic ssf, input logic [2:0] lbl);
    expect_rdi = ssf | (lbl == 3'h0);
  endfunction : expect_rdi
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // waits are whole frames plus slack for the status crossing
  task automatic frames(input int n);
    repeat (n * 210) @(posedge i_clk);
  endtask : frames
  task automatic results;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (30000) @(posedge i_clk);
    error_cnt++;
    results();
  end
  initial
  begin
    void'($urandom(32'h3e25d5dc));
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    frames(3);
    // change trace just after V5 so the J2 slot sees a settled value
    @(posedge o_src_fs);
    @(posedge i_clk);
    i_transmitted_trace_id <= 8'($urandom);
    label <= 3'($urandom) | 3'h4;
    frames(3);
    chk("trace", i_transmitted_trace_id, o_accepted_trace_id);
    chk("label", {5'h00, label}, {5'h00, o_signal_label});
    chk("rdi", {7'h00, expect_rdi(i_snk_ssf, label)}, {7'h00, o_remote_receiver_defect});
    $display("test trace done");
    for (int n = 1; n <= 2; n++)
    begin
      nb = near_n;
      fb = far_n;
      @(posedge i_link_clk);
      err <= n[1:0] | 2'h1;
      @(posedge i_link_clk);
      err <= 2'h0;
      frames(4);
      chk("near", 8'h01, 8'(near_n - nb));
      chk("far", 8'h01, 8'(far_n - fb));
    end
    $display("test bip done");
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge i_link_clk);
      i_snk_ssf <= v[0];
      frames(2);
      chk("rdi", {7'h00, expect_rdi(v[0], label)}, {7'h00, o_remote_receiver_defect});
    end
    @(posedge i_link_clk);
    label <= 3'h0;
    frames(3);
    chk("uneq", 8'h01, {7'h00, o_unequipped});
    chk("rdi", {7'h00, expect_rdi(1'b0, label)}, {7'h00, o_remote_receiver_defect});
    label <= 3'h5;
    frames(3);
    $display("test defect done");
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge i_clk);
      i_alarm_insert_action <= v[0];
      repeat (10) @(posedge i_clk);
      repeat (8)
      begin
        @(negedge i_link_clk);
        chk("snk", v ? 8'hff : prev, o_snk_data);
        chk("snk fs", {7'h00, prev_fs}, {7'h00, o_snk_fs});
      end
    end
    $display("test alarm done");
    results();
  end
endmodule : vc2_path_overhead_termination_bench
`default_nettype wire
